// *** hdl/dafc_regs.sv ***
// How it works
// - bit0 of features enables overrange pin
// - master sync bit gates all sync
// - divider sync needs both bits; continuous
// - one-shot: take first pulse, ignore rest
// - one-shot clears divider sync enable itself
// - user bit7 lets output-enable pin act
// - user bit3 enables slow-clock detector oscillator
// - user bit2 forces slow oscillator on
// - user bit0 disables data pin pull-down
// - freeze bits hold terms, stop estimation
// - separate gain, phase, dc enables
// - force dc selects initial I and Q
// - force phase selects initial phase
// - force gain selects initial gain
// - gain loop exponent, reset two
// - phase loop exponent, independent
// - dc loop exponent, independent
// - initial gain fifteen bits split
// - initial dc I,Q fourteen bits split
// - initial phase thirteen bits, force only
module dafc_regs (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // register port from serial control logic
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [9:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [1:0] chan_index,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // sync input and divider alignment
   input wire logic sync_pulse,
   output logic div_align,
   // pin and oscillator status
   input wire logic output_enable_pin_n,
   input wire logic low_rate_detected,
   output logic outputs_enabled,
   output logic low_rate_oscillator_run,
   output logic data_pulldown_en,
   output logic [1:0] overrange_pin_en,
   output logic [1:0] chan_adc_select,
   // correction controls
   output logic [2:0] corr_enable,
   output logic [2:0] corr_freeze,
   output logic [2:0] estimate_run,
   output logic [2:0] corr_force,
   output logic [4:0] gain_loop_exponent,
   output logic [4:0] phase_loop_exponent,
   output logic [4:0] dc_loop_exponent,
   output logic [14:0] gain_init_value,
   output logic [12:0] phase_init_value,
   output logic [13:0] dc_i_init_value,
   output logic [13:0] dc_q_init_value
);
   logic [1:0] features_reg;
   logic [1:0] out_assign_reg;
   logic [7:0] sync_reg;
   logic [7:0] user_two_reg;
   logic [7:0] qec_a_reg;
   logic [7:0] qec_b_reg;
   logic [7:0] gain_bw_reg;
   logic [7:0] phase_bw_reg;
   logic [7:0] dc_bw_reg;
   logic [7:0] gain_lo_reg;
   logic [7:0] gain_hi_reg;
   logic [7:0] phase_lo_reg;
   logic [7:0] phase_hi_reg;
   logic [7:0] dci_lo_reg;
   logic [7:0] dci_hi_reg;
   logic [7:0] dcq_lo_reg;
   logic [7:0] dcq_hi_reg;
   logic sync_active;
   logic one_shot_hit;
   logic [7:0] rdata_next;

   // sync is live only with master and divider enables set
   assign sync_active = sync_reg[dafc_pkg::SYNC_MASTER] & sync_reg[dafc_pkg::SYNC_DIV_EN];
   assign one_shot_hit = sync_active & sync_reg[dafc_pkg::SYNC_ONE_SHOT] & sync_pulse;

   // per-channel local bits, written for indexed channels
   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_chan
         always_ff @(posedge mclk) begin
            if (!rst_n) begin
               features_reg[ch] <= dafc_pkg::RST_FEATURES[0];
               out_assign_reg[ch] <= (ch == dafc_pkg::CH_B);
            end else if (reg_wr && chan_index[ch]) begin
               if (reg_addr == dafc_pkg::ADDR_FEATURES) begin
                  features_reg[ch] <= reg_wdata[0];
               end
               if (reg_addr == dafc_pkg::ADDR_OUT_ASSIGN) begin
                  out_assign_reg[ch] <= reg_wdata[0];
               end
            end
         end
      end
   endgenerate

   // sync control; hardware clear of divider enable wins over a write
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sync_reg <= dafc_pkg::RST_SYNC_CTRL;
      end else begin
         if (reg_wr && reg_addr == dafc_pkg::ADDR_SYNC_CTRL) begin
            sync_reg <= reg_wdata & dafc_pkg::MASK_SYNC;
         end
         if (one_shot_hit) begin
            sync_reg[dafc_pkg::SYNC_DIV_EN] <= 1'b0;
         end
      end
   end

   // user control and correction control registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         user_two_reg <= dafc_pkg::RST_USER_CTRL_TWO;
         qec_a_reg <= 8'h00;
         qec_b_reg <= 8'h00;
      end else if (reg_wr) begin
         case (reg_addr)
            dafc_pkg::ADDR_USER_CTRL_TWO: user_two_reg <= reg_wdata & dafc_pkg::MASK_USER_TWO;
            dafc_pkg::ADDR_QEC_CTRL_A: qec_a_reg <= reg_wdata & dafc_pkg::MASK_QEC_A;
            dafc_pkg::ADDR_QEC_CTRL_B: qec_b_reg <= reg_wdata & dafc_pkg::MASK_QEC_B;
            default: ;
         endcase
      end
   end

   // loop bandwidth exponents; open top bits dropped on write
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         gain_bw_reg <= {3'h0, dafc_pkg::RST_LOOP_EXP};
         phase_bw_reg <= {3'h0, dafc_pkg::RST_LOOP_EXP};
         dc_bw_reg <= {3'h0, dafc_pkg::RST_LOOP_EXP};
      end else if (reg_wr) begin
         case (reg_addr)
            dafc_pkg::ADDR_GAIN_BW: gain_bw_reg <= reg_wdata & dafc_pkg::MASK_EXP;
            dafc_pkg::ADDR_PHASE_BW: phase_bw_reg <= reg_wdata & dafc_pkg::MASK_EXP;
            dafc_pkg::ADDR_DC_BW: dc_bw_reg <= reg_wdata & dafc_pkg::MASK_EXP;
            default: ;
         endcase
      end
   end

   // initial correction values; each byte takes effect on its own
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         gain_lo_reg <= 8'h00;
         gain_hi_reg <= 8'h00;
         phase_lo_reg <= 8'h00;
         phase_hi_reg <= 8'h00;
         dci_lo_reg <= 8'h00;
         dci_hi_reg <= 8'h00;
         dcq_lo_reg <= 8'h00;
         dcq_hi_reg <= 8'h00;
      end else if (reg_wr) begin
         case (reg_addr)
            dafc_pkg::ADDR_INIT_GAIN_LO: gain_lo_reg <= reg_wdata;
            dafc_pkg::ADDR_INIT_GAIN_HI: gain_hi_reg <= reg_wdata & dafc_pkg::MASK_GAIN_HI;
            dafc_pkg::ADDR_INIT_PHASE_LO: phase_lo_reg <= reg_wdata;
            dafc_pkg::ADDR_INIT_PHASE_HI: phase_hi_reg <= reg_wdata & dafc_pkg::MASK_PHASE_HI;
            dafc_pkg::ADDR_INIT_DCI_LO: dci_lo_reg <= reg_wdata;
            dafc_pkg::ADDR_INIT_DCI_HI: dci_hi_reg <= reg_wdata & dafc_pkg::MASK_DC_HI;
            dafc_pkg::ADDR_INIT_DCQ_LO: dcq_lo_reg <= reg_wdata;
            dafc_pkg::ADDR_INIT_DCQ_HI: dcq_hi_reg <= reg_wdata & dafc_pkg::MASK_DC_HI;
            default: ;
         endcase
      end
   end

   // read mux; per-channel reads return the lowest indexed channel
   always_comb begin
      rdata_next = 8'h00;
      case (reg_addr)
         dafc_pkg::ADDR_FEATURES:
            rdata_next = {7'h00, chan_index[0] ? features_reg[0] : features_reg[1]};
         dafc_pkg::ADDR_OUT_ASSIGN:
            rdata_next = {7'h00, chan_index[0] ? out_assign_reg[0] : out_assign_reg[1]};
         dafc_pkg::ADDR_SYNC_CTRL: rdata_next = sync_reg;
         dafc_pkg::ADDR_USER_CTRL_TWO: rdata_next = user_two_reg;
         dafc_pkg::ADDR_QEC_CTRL_A: rdata_next = qec_a_reg;
         dafc_pkg::ADDR_QEC_CTRL_B: rdata_next = qec_b_reg;
         dafc_pkg::ADDR_GAIN_BW: rdata_next = gain_bw_reg;
         dafc_pkg::ADDR_PHASE_BW: rdata_next = phase_bw_reg;
         dafc_pkg::ADDR_DC_BW: rdata_next = dc_bw_reg;
         dafc_pkg::ADDR_INIT_GAIN_LO: rdata_next = gain_lo_reg;
         dafc_pkg::ADDR_INIT_GAIN_HI: rdata_next = gain_hi_reg;
         dafc_pkg::ADDR_INIT_PHASE_LO: rdata_next = phase_lo_reg;
         dafc_pkg::ADDR_INIT_PHASE_HI: rdata_next = phase_hi_reg;
         dafc_pkg::ADDR_INIT_DCI_LO: rdata_next = dci_lo_reg;
         dafc_pkg::ADDR_INIT_DCI_HI: rdata_next = dci_hi_reg;
         dafc_pkg::ADDR_INIT_DCQ_LO: rdata_next = dcq_lo_reg;
         dafc_pkg::ADDR_INIT_DCQ_HI: rdata_next = dcq_hi_reg;
         default: rdata_next = 8'h00;
      endcase
   end

   // read answer flag, one cycle after the strobe
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
      end
   end

   // read data, held until the next read
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_next;
      end
   end

   // divider alignment pulse: continuous or first pulse only
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         div_align <= 1'b0;
      end else begin
         div_align <= sync_active & sync_pulse;
      end
   end

   // output-enable pin gates outputs only while its control bit is set
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         outputs_enabled <= 1'b1;
      end else begin
         outputs_enabled <= ~user_two_reg[dafc_pkg::USR_OE_PIN_EN] | ~output_enable_pin_n;
      end
   end

   // slow oscillator: forced on, or started by the rate detector
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         low_rate_oscillator_run <= 1'b0;
      end else begin
         low_rate_oscillator_run <= user_two_reg[dafc_pkg::USR_RUN_OSC] |
            (user_two_reg[dafc_pkg::USR_DETECT_EN] & low_rate_detected);
      end
   end

   // data pin pull-down, on unless disabled
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         data_pulldown_en <= 1'b1;
      end else begin
         data_pulldown_en <= ~user_two_reg[dafc_pkg::USR_PULLDN_DIS];
      end
   end

   // overrange pin enable per channel
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         overrange_pin_en <= 2'h3;
      end else begin
         overrange_pin_en <= features_reg;
      end
   end

   // converter routed to each output channel
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         chan_adc_select <= 2'h2;
      end else begin
         chan_adc_select <= out_assign_reg;
      end
   end

   // correction enables, dc, phase, gain from high to low
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         corr_enable <= 3'h0;
      end else begin
         corr_enable <= qec_a_reg[2:0];
      end
   end

   // freeze bits hold each correction term
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         corr_freeze <= 3'h0;
      end else begin
         corr_freeze <= qec_a_reg[5:3];
      end
   end

   // estimation runs for enabled terms that are not frozen
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         estimate_run <= 3'h0;
      end else begin
         estimate_run <= qec_a_reg[2:0] & ~qec_a_reg[5:3];
      end
   end

   // force bits select the static initial values
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         corr_force <= 3'h0;
      end else begin
         corr_force <= qec_b_reg[2:0];
      end
   end

   // gain loop time constant
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         gain_loop_exponent <= dafc_pkg::RST_LOOP_EXP;
      end else begin
         gain_loop_exponent <= gain_bw_reg[4:0];
      end
   end

   // phase loop time constant
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         phase_loop_exponent <= dafc_pkg::RST_LOOP_EXP;
      end else begin
         phase_loop_exponent <= phase_bw_reg[4:0];
      end
   end

   // dc loop time constant
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         dc_loop_exponent <= dafc_pkg::RST_LOOP_EXP;
      end else begin
         dc_loop_exponent <= dc_bw_reg[4:0];
      end
   end

   // initial gain, presented only when forced
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         gain_init_value <= 15'h0000;
      end else begin
         gain_init_value <= qec_b_reg[dafc_pkg::QEC_GAIN] ?
            {gain_hi_reg[6:0], gain_lo_reg} : 15'h0000;
      end
   end

   // initial phase, presented only when forced
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         phase_init_value <= 13'h0000;
      end else begin
         phase_init_value <= qec_b_reg[dafc_pkg::QEC_PHASE] ?
            {phase_hi_reg[4:0], phase_lo_reg} : 13'h0000;
      end
   end

   // initial dc for I, presented only when forced
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         dc_i_init_value <= 14'h0000;
      end else begin
         dc_i_init_value <= qec_b_reg[dafc_pkg::QEC_DC] ?
            {dci_hi_reg[5:0], dci_lo_reg} : 14'h0000;
      end
   end

   // initial dc for Q, presented only when forced
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         dc_q_init_value <= 14'h0000;
      end else begin
         dc_q_init_value <= qec_b_reg[dafc_pkg::QEC_DC] ?
            {dcq_hi_reg[5:0], dcq_lo_reg} : 14'h0000;
      end
   end
endmodule : dafc_regs

// *** hdl/dafc_pkg.sv ***
package dafc_pkg;
   // register addresses on the serial control port
   localparam logic [9:0] ADDR_FEATURES = 10'h02A;
   localparam logic [9:0] ADDR_OUT_ASSIGN = 10'h02E;
   localparam logic [9:0] ADDR_SYNC_CTRL = 10'h100;
   localparam logic [9:0] ADDR_USER_CTRL_TWO = 10'h101;
   localparam logic [9:0] ADDR_QEC_CTRL_A = 10'h110;
   localparam logic [9:0] ADDR_QEC_CTRL_B = 10'h111;
   localparam logic [9:0] ADDR_GAIN_BW = 10'h112;
   localparam logic [9:0] ADDR_PHASE_BW = 10'h113;
   localparam logic [9:0] ADDR_DC_BW = 10'h114;
   localparam logic [9:0] ADDR_INIT_GAIN_LO = 10'h116;
   localparam logic [9:0] ADDR_INIT_GAIN_HI = 10'h117;
   localparam logic [9:0] ADDR_INIT_PHASE_LO = 10'h118;
   localparam logic [9:0] ADDR_INIT_PHASE_HI = 10'h119;
   localparam logic [9:0] ADDR_INIT_DCI_LO = 10'h11A;
   localparam logic [9:0] ADDR_INIT_DCI_HI = 10'h11B;
   localparam logic [9:0] ADDR_INIT_DCQ_LO = 10'h11C;
   localparam logic [9:0] ADDR_INIT_DCQ_HI = 10'h11D;
   // reset values
   localparam logic [7:0] RST_FEATURES = 8'h01;
   localparam logic [7:0] RST_SYNC_CTRL = 8'h01;
   localparam logic [7:0] RST_USER_CTRL_TWO = 8'h88;
   localparam logic [4:0] RST_LOOP_EXP = 5'h02;
   // writable masks; open bits read zero
   localparam logic [7:0] MASK_BIT0 = 8'h01;
   localparam logic [7:0] MASK_SYNC = 8'h07;
   localparam logic [7:0] MASK_USER_TWO = 8'h8D;
   localparam logic [7:0] MASK_QEC_A = 8'h3F;
   localparam logic [7:0] MASK_QEC_B = 8'h07;
   localparam logic [7:0] MASK_EXP = 8'h1F;
   localparam logic [7:0] MASK_GAIN_HI = 8'h7F;
   localparam logic [7:0] MASK_PHASE_HI = 8'h1F;
   localparam logic [7:0] MASK_DC_HI = 8'h3F;
   // field positions
   localparam int SYNC_MASTER = 0;
   localparam int SYNC_DIV_EN = 1;
   localparam int SYNC_ONE_SHOT = 2;
   localparam int USR_OE_PIN_EN = 7;
   localparam int USR_DETECT_EN = 3;
   localparam int USR_RUN_OSC = 2;
   localparam int USR_PULLDN_DIS = 0;
   localparam int QEC_GAIN = 0;
   localparam int QEC_PHASE = 1;
   localparam int QEC_DC = 2;
   localparam int QEC_FREEZE_OFS = 3;
   // channel index bits
   localparam int CH_A = 0;
   localparam int CH_B = 1;
endpackage : dafc_pkg

// *** dv/dafc_regs_monitor.sv ***
module dafc_regs_monitor (
   // clock, reset and register port
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [9:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // derived controls
   input wire logic sync_pulse,
   input wire logic div_align,
   input wire logic outputs_enabled,
   input wire logic data_pulldown_en,
   input wire logic low_rate_oscillator_run,
   input wire logic [2:0] corr_enable,
   input wire logic [2:0] corr_freeze,
   input wire logic [2:0] estimate_run,
   input wire logic [4:0] gain_loop_exponent,
   input wire logic [14:0] gain_init_value
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // writes show on derived outputs two edges after the strobe
   open_read_a: assert property (
      reg_rd && reg_addr == 10'h115 |=> reg_rdata == 8'h00) else $error("open read nonzero");
   align_cause_a: assert property (
      div_align |-> $past(sync_pulse)) else $error("align without sync pulse");
   pulldown_off_a: assert property (
      reg_wr && reg_addr == 10'h101 |-> ##2 data_pulldown_en == !$past(reg_wdata[0], 2))
      else $error("pull-down control wrong");
   osc_force_a: assert property (
      reg_wr && reg_addr == 10'h101 && reg_wdata[2] |-> ##2 low_rate_oscillator_run)
      else $error("oscillator not forced on");
   oe_ignore_a: assert property (
      reg_wr && reg_addr == 10'h101 && !reg_wdata[7] |-> ##2 outputs_enabled)
      else $error("ignored pin still gates outputs");
   estimate_stop_a: assert property (
      estimate_run == (corr_enable & ~corr_freeze)) else $error("estimation state wrong");
   gain_exp_a: assert property (
      reg_wr && reg_addr == 10'h112 |-> ##2 gain_loop_exponent == $past(reg_wdata[4:0], 2))
      else $error("gain exponent wrong");
   gain_unforced_a: assert property (
      reg_wr && reg_addr == 10'h111 && !reg_wdata[0] |-> ##2 gain_init_value == 15'h0000)
      else $error("unforced gain value not zero");
   // main scenarios reached
   cover property (div_align);
   cover property (reg_wr && reg_addr == 10'h100 && reg_wdata == 8'h07);
   cover property (estimate_run != corr_enable);
endmodule : dafc_regs_monitor
bind dafc_regs dafc_regs_monitor dafc_regs_monitor_i (.*);

// *** dv/dafc_host.sv ***
module dafc_host (
   // clock
   input wire logic mclk,
   // register port towards the block
   output logic reg_wr,
   output logic reg_rd,
   output logic [9:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic [1:0] chan_index,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle port at time zero
   initial {reg_wr, reg_rd, reg_addr, reg_wdata, chan_index} = '0;
   // one-cycle write strobe; released lines show inverted values
   task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] ch);
      @(negedge mclk);
      {reg_addr, reg_wdata, chan_index, reg_wr} = {a, d, ch, 1'b1};
      @(negedge mclk);
      {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
   endtask : wr
   // read strobe, address held until the answer is taken
   task automatic rd(input logic [9:0] a, input logic [1:0] ch, output logic [7:0] d,
                     output bit ok);
      {d, ok} = '0;
      @(negedge mclk);
      {reg_addr, chan_index, reg_rd} = {a, ch, 1'b1};
      @(negedge mclk);
      reg_rd = 1'b0;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (reg_rvalid === 1'b1) {d, ok} = {reg_rdata, 1'b1};
         else @(negedge mclk);
      end
      reg_addr = ~a;
   endtask : rd
endmodule : dafc_host

// *** dv/tb_top.sv ***
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic sync_pulse = 1'b0;
   logic output_enable_pin_n = 1'b1;
   logic low_rate_detected = 1'b0;
   logic reg_wr, reg_rd, reg_rvalid, div_align, outputs_enabled, low_rate_oscillator_run;
   logic data_pulldown_en;
   logic [1:0] chan_index, overrange_pin_en, chan_adc_select;
   logic [9:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [2:0] corr_enable, corr_freeze, estimate_run, corr_force;
   logic [4:0] gain_loop_exponent, phase_loop_exponent, dc_loop_exponent;
   logic [14:0] gain_init_value;
   logic [12:0] phase_init_value;
   logic [13:0] dc_i_init_value, dc_q_init_value;
   int bad_count = 0;
   int checks = 0;
   // map: address, writable bits, reset value; last entry is unmapped
   logic [9:0] adr [18] = '{10'h02A, 10'h02E, 10'h100, 10'h101, 10'h110, 10'h111, 10'h112,
      10'h113, 10'h114, 10'h116, 10'h117, 10'h118, 10'h119, 10'h11A, 10'h11B, 10'h11C,
      10'h11D, 10'h115};
   logic [7:0] msk [18] = '{8'h01, 8'h01, 8'h07, 8'h8D, 8'h3F, 8'h07, 8'h1F, 8'h1F, 8'h1F,
      8'hFF, 8'h7F, 8'hFF, 8'h1F, 8'hFF, 8'h3F, 8'hFF, 8'h3F, 8'h00};
   logic [7:0] rv [18] = '{8'h01, 8'h00, 8'h01, 8'h88, 8'h00, 8'h00, 8'h02, 8'h02, 8'h02,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   dafc_regs dafc_regs_i (.*);
   dafc_host dafc_host_i (.*);
   always #25 mclk = ~mclk;
   // compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic give_verdict();
      if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   // read through the host and compare; a lost answer ends the run
   task automatic rdc(input logic [9:0] a, input logic [1:0] ch, input logic [7:0] e);
      logic [7:0] d;
      bit ok;
      dafc_host_i.rd(a, ch, d, ok);
      if (!ok) begin
         bad_count++;
         give_verdict();
      end
      else chk(d, e);
   endtask : rdc
   // expected initial value: register pair when forced, else zero
   function automatic logic [15:0] pair(input logic f, input logic [7:0] hi, input logic [7:0] lo);
      pair = f ? {hi, lo} : 16'h0000;
   endfunction : pair
   // one sync pulse, then count alignment pulses
   task automatic pulse(output int n);
      n = 0;
      @(negedge mclk) sync_pulse = 1'b1;
      repeat (4) begin
         @(negedge mclk) sync_pulse = 1'b0;
         n += int'(div_align === 1'b1);
      end
   endtask : pulse
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      for (int k = 0; k < 18; k++) rdc(adr[k], 2'b01, rv[k]);
      rdc(10'h02E, 2'b10, 8'h01);
      chk({overrange_pin_en, chan_adc_select, gain_loop_exponent}, 9'h1C2);
   endtask : do_reset
   initial begin
      logic [7:0] a, b, d;
      logic [7:0] v [8];
      int k, n;
      k = $urandom(99);
      do_reset();
      // random writes to addresses drawn at random from the map, open bits masked on read
      repeat (40) begin
         k = $urandom_range(17);
         d = $urandom;
         dafc_host_i.wr(adr[k], d, 2'b11);
         rdc(adr[k], 2'b01, d & msk[k]);
      end
      // per-channel writes follow the index; index zero is ignored
      dafc_host_i.wr(10'h02E, 8'h00, 2'b11);
      dafc_host_i.wr(10'h02E, 8'h01, 2'b01);
      dafc_host_i.wr(10'h02A, 8'h01, 2'b11);
      dafc_host_i.wr(10'h02A, 8'h00, 2'b10);
      dafc_host_i.wr(10'h02A, 8'h00, 2'b00);
      repeat (2) @(negedge mclk);
      chk({chan_adc_select, overrange_pin_en}, 4'h5);
      // every combination of the user control bits
      for (k = 0; k < 16; k++) begin
         d = {k[3], 3'b000, k[2], k[1], 1'b0, k[0]};
         output_enable_pin_n = 1'($urandom);
         low_rate_detected = 1'($urandom);
         dafc_host_i.wr(10'h101, d, 2'b11);
         repeat (2) @(negedge mclk);
         chk(outputs_enabled, !d[7] || !output_enable_pin_n);
         chk(low_rate_oscillator_run, d[2] || (d[3] && low_rate_detected));
         chk(data_pulldown_en, !d[0]);
      end
      // correction controls, initial values and loop exponents
      repeat (12) begin
         a = $urandom;
         b = $urandom;
         dafc_host_i.wr(10'h110, a, 2'b11);
         dafc_host_i.wr(10'h111, b, 2'b11);
         for (k = 0; k < 8; k++) begin
            v[k] = $urandom;
            dafc_host_i.wr(10'h116 + 10'(k), v[k], 2'b11);
         end
         for (k = 0; k < 3; k++) dafc_host_i.wr(10'h112 + 10'(k), v[2 * k], 2'b11);
         repeat (2) @(negedge mclk);
         chk({corr_freeze, corr_enable, corr_force}, {a[5:0], b[2:0]});
         chk(estimate_run, a[2:0] & ~a[5:3]);
         chk(gain_init_value, pair(b[0], v[1] & 8'h7F, v[0]));
         chk(phase_init_value, pair(b[1], v[3] & 8'h1F, v[2]));
         chk(dc_i_init_value, pair(b[2], v[5] & 8'h3F, v[4]));
         chk(dc_q_init_value, pair(b[2], v[7] & 8'h3F, v[6]));
         chk({gain_loop_exponent, phase_loop_exponent, dc_loop_exponent},
             {v[0][4:0], v[2][4:0], v[4][4:0]});
      end
      // one-shot, continuous and master-off sync
      dafc_host_i.wr(10'h100, 8'h07, 2'b11);
      pulse(n);
      chk(16'(n), 16'h0001);
      rdc(10'h100, 2'b11, 8'h05);
      pulse(n);
      chk(16'(n), 16'h0000);
      dafc_host_i.wr(10'h100, 8'h03, 2'b11);
      pulse(n);
      chk(16'(n), 16'h0001);
      pulse(n);
      chk(16'(n), 16'h0001);
      dafc_host_i.wr(10'h100, 8'h06, 2'b11);
      pulse(n);
      chk(16'(n), 16'h0000);
      do_reset();
      give_verdict();
   end
endmodule : tb_top
